/* File: shared/pcs_pkg.sv */
package pcs_pkg;
	// access kinds requested by the host bridge
	typedef enum logic [1:0] {
		PCS_MEM    = 2'b00,
		PCS_ATTR   = 2'b01,
		PCS_IO     = 2'b10,
		PCS_RSVD   = 2'b11
	} pcs_space_e;

	// host request carrier
	typedef struct packed {
		pcs_space_e  space;
		logic        write;
		logic [25:0] addr;
		logic [15:0] wdata;
		logic        wide;  // 16-bit transfer
	} pcs_req_s;

	// card-side strobe group, all active low
	typedef struct packed {
		logic ce1_n;
		logic ce2_n;
		logic oe_n;
		logic we_n;
		logic iord_n;
		logic iowr_n;
		logic reg_n;
	} pcs_strb_s;

	// card status decoded for the host
	typedef struct packed {
		logic       ready;
		logic       ireq;
		logic       wprot;
		logic       iois16;
		logic [1:0] volt;
	} pcs_stat_s;

	localparam pcs_strb_s PCS_STRB_IDLE = 7'h7f;
	localparam int        PCS_SETUP_NS  = 100;
	localparam int        PCS_STRB_NS   = 300;
	localparam int        PCS_HOLD_NS   = 50;
	localparam int        PCS_CLK_NS    = 50;
	localparam logic [3:0] PCS_SETUP_CYC = 4'((PCS_SETUP_NS + PCS_CLK_NS - 1) / PCS_CLK_NS);
	localparam logic [3:0] PCS_STRB_CYC  = 4'((PCS_STRB_NS + PCS_CLK_NS - 1) / PCS_CLK_NS);
	localparam logic [3:0] PCS_HOLD_CYC  = 4'((PCS_HOLD_NS + PCS_CLK_NS - 1) / PCS_CLK_NS);
	localparam logic [1:0] PCS_VS_5V     = 2'b11;
	localparam logic [1:0] PCS_VS_3V     = 2'b10;
	localparam logic [1:0] PCS_VS_XV     = 2'b01;
	localparam logic [1:0] PCS_VS_YV     = 2'b00;
endpackage : pcs_pkg

/* File: rtl/pcs_socket.sv */
`timescale 1ns/1ps
module pcs_socket import pcs_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  wire pcs_req_s    req,
	input  wire logic        io_mode,
	input  wire logic        card_rst_req,
	output pcs_stat_s        stat,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             inpack_seen,
	output pcs_strb_s        strb,
	output logic             card_reset,
	output logic [25:0]      card_addr,
	output logic [15:0]      card_dout,
	output logic             card_doe_n,
	input  wire logic [15:0] card_din,
	input  wire logic        rdy_ireq_in,
	input  wire logic        wait_n,
	input  wire logic        inpack_n,
	input  wire logic        wp_in,
	input  wire logic        vs1_n,
	input  wire logic        vs2_n
);

	typedef enum logic [1:0] {
		PCS_IDLE  = 2'b00,
		PCS_SETUP = 2'b01,
		PCS_STRB  = 2'b10,
		PCS_HOLD  = 2'b11
	} pcs_state_e;

	// byte enables {ce1_n, ce2_n} from the low address bit and width: even byte on ce1, odd byte on ce2
	function automatic logic [1:0] pcs_ce(input logic a0, input logic wide);
		pcs_ce = wide ? 2'b00 : (a0 ? 2'b10 : 2'b01);
	endfunction : pcs_ce

	pcs_state_e state;
	pcs_state_e next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	pcs_req_s   cur;
	pcs_req_s   next_cur;
	pcs_strb_s  next_strb;
	logic       next_busy;
	logic       next_done;
	logic [15:0] next_rdata;
	logic       next_inpack_seen;
	logic       next_doe_n;
	logic [1:0] ce;

	// transfer sequencer: setup, strobe stretched by wait, hold
	always_comb begin
		next_state       = state;
		next_cnt         = cnt;
		next_cur         = cur;
		next_strb        = strb;
		next_busy        = busy;
		next_done        = 1'b0;
		next_rdata       = rdata;
		next_inpack_seen = inpack_seen;
		next_doe_n       = card_doe_n;
		ce               = pcs_ce(cur.addr[0], cur.wide);
		case (state)
			PCS_IDLE: begin
				next_strb  = PCS_STRB_IDLE;
				next_doe_n = 1'b1;
				if (req_valid && !card_reset && req.space != PCS_RSVD) begin
					next_cur         = req;
					next_busy        = 1'b1;
					next_cnt         = PCS_SETUP_CYC;
					next_inpack_seen = 1'b0;
					next_state       = PCS_SETUP;
				end
			end
			PCS_SETUP: begin
				// address, selects and attribute line settle before the strobe
				next_strb.ce1_n = ce[1];
				next_strb.ce2_n = ce[0];
				next_strb.reg_n = (cur.space == PCS_MEM);
				next_doe_n      = ~cur.write;
				if (cnt <= 4'h1) begin
					next_cnt = PCS_STRB_CYC;
					// exactly one strobe per access keeps reads and writes apart
					next_strb.oe_n   = !(cur.space != PCS_IO && !cur.write);
					next_strb.we_n   = !(cur.space != PCS_IO && cur.write);
					next_strb.iord_n = !(cur.space == PCS_IO && !cur.write);
					next_strb.iowr_n = !(cur.space == PCS_IO && cur.write);
					next_state       = PCS_STRB;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			PCS_STRB: begin
				if (!inpack_n && cur.space == PCS_IO && !cur.write)
					next_inpack_seen = 1'b1;
				if (cnt > 4'h1) begin
					next_cnt = cnt - 4'h1;
				end else if (wait_n) begin
					next_rdata       = card_din;
					next_strb.oe_n   = 1'b1;
					next_strb.we_n   = 1'b1;
					next_strb.iord_n = 1'b1;
					next_strb.iowr_n = 1'b1;
					next_cnt         = PCS_HOLD_CYC;
					next_state       = PCS_HOLD;
				end
			end
			PCS_HOLD: begin
				if (cnt <= 4'h1) begin
					next_strb  = PCS_STRB_IDLE;
					next_doe_n = 1'b1;
					next_busy  = 1'b0;
					next_done  = 1'b1;
					next_state = PCS_IDLE;
				end else begin
					next_cnt = cnt - 4'h1;
				end
			end
			default: begin
				next_state = PCS_IDLE;
				next_strb  = PCS_STRB_IDLE;
				next_busy  = 1'b0;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state       <= PCS_IDLE;
			cnt         <= 4'h0;
			cur         <= '0;
			strb        <= PCS_STRB_IDLE;
			busy        <= 1'b0;
			done        <= 1'b0;
			rdata       <= 16'h0000;
			inpack_seen <= 1'b0;
			card_doe_n  <= 1'b1;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			cur         <= next_cur;
			strb        <= next_strb;
			busy        <= next_busy;
			done        <= next_done;
			rdata       <= next_rdata;
			inpack_seen <= next_inpack_seen;
			card_doe_n  <= next_doe_n;
		end
	end

	logic       next_card_reset;
	logic [25:0] next_card_addr;
	logic [15:0] next_card_dout;
	pcs_stat_s  next_stat;

	// card reset, bus drive and status decode
	always_comb begin
		next_card_reset = card_rst_req;
		next_card_addr  = (state == PCS_IDLE) ? card_addr : cur.addr;
		next_card_dout  = (state == PCS_IDLE) ? card_dout : cur.wdata;
		next_stat.ready  = !io_mode && rdy_ireq_in;
		next_stat.ireq   = io_mode && !rdy_ireq_in;
		next_stat.wprot  = !io_mode && wp_in;
		next_stat.iois16 = io_mode && !wp_in;
		next_stat.volt   = {vs2_n, vs1_n};
	end

	// output registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			card_reset <= 1'b1;
			card_addr  <= 26'h000_0000;
			card_dout  <= 16'h0000;
			stat       <= '0;
		end else begin
			card_reset <= next_card_reset;
			card_addr  <= next_card_addr;
			card_dout  <= next_card_dout;
			stat       <= next_stat;
		end
	end

endmodule : pcs_socket

/* File: test/pcs_socket_monitor.sv */
`timescale 1ns/1ps
module pcs_socket_monitor import pcs_pkg::*; (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        io_mode,
	input wire logic        rdy_ireq_in,
	input wire logic        wait_n,
	input wire logic        wp_in,
	input wire logic        vs1_n,
	input wire logic        vs2_n,
	input wire pcs_stat_s   stat,
	input wire logic        done,
	input wire pcs_strb_s   strb,
	input wire logic [25:0] card_addr
);
	// any data strobe low
	wire act = !(strb.oe_n && strb.we_n && strb.iord_n && strb.iowr_n);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_no_overlap: assert property (!((!strb.oe_n || !strb.iord_n) && (!strb.we_n || !strb.iowr_n)))
		else $error("strobe overlap");
	a_io_attr: assert property (!(strb.iord_n && strb.iowr_n) |-> !strb.reg_n)
		else $error("io without reg");
	a_byte_lane: assert property (act |-> (!strb.ce1_n && !strb.ce2_n) ||
		(strb.ce1_n == card_addr[0] && strb.ce2_n != card_addr[0])) else $error("byte lane");
	a_mem_stat: assert property (!io_mode |=> stat.ready == $past(rdy_ireq_in) && stat.wprot == $past(wp_in))
		else $error("memory status");
	a_io_stat: assert property (io_mode |=> stat.ireq != $past(rdy_ireq_in) && stat.iois16 != $past(wp_in))
		else $error("io status");
	a_volt_sense: assert property (1 |=> stat.volt == {$past(vs2_n), $past(vs1_n)})
		else $error("voltage");
	a_wait_hold: assert property (act && !wait_n |=> act) else $error("wait");
	a_done_end: assert property ($fell(act) |=> done) else $error("done");
	c_io_rd: cover property (!strb.iord_n);
	c_wait: cover property (act && !wait_n);
	c_wr: cover property (!strb.we_n);
endmodule : pcs_socket_monitor
bind pcs_socket pcs_socket_monitor i_pcs_socket_monitor (.sys_clk, .nrst, .io_mode, .rdy_ireq_in, .wait_n,
	.wp_in, .vs1_n, .vs2_n, .stat, .done, .strb, .card_addr);

/* File: test/pcs_card.sv */
`timescale 1ns/1ps
module pcs_card import pcs_pkg::*; (
	input wire logic        sys_clk,
	input wire pcs_strb_s   strb,
	input wire logic [25:0] card_addr,
	input wire logic        io_card,
	input wire logic        flag,
	input wire logic        wp_sw,
	input wire logic [3:0]  nwait,
	output logic [15:0]     card_din,
	output logic            rdy_ireq_in,
	output logic            wait_n,
	output logic            inpack_n,
	output logic            wp_in
);
	logic [3:0] cnt = 4'h0;
	wire act = !(strb.oe_n && strb.we_n && strb.iord_n && strb.iowr_n);
	// strobe cycle count places the wait request
	always @(posedge sys_clk) cnt <= act ? cnt + 4'h1 : 4'h0;
	assign wait_n = !(act && cnt < 4'h5 + nwait);
	// data only while read strobe is low, inverted otherwise
	assign card_din = (!strb.oe_n || !strb.iord_n) ? card_addr[15:0] : ~card_addr[15:0];
	assign inpack_n = !(io_card && !strb.iord_n);
	// flag: busy write in memory mode, service request in io mode
	assign rdy_ireq_in = !flag;
	assign wp_in = io_card ? !(!strb.reg_n && !card_addr[8]) : wp_sw;
endmodule : pcs_card

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb import pcs_pkg::*;;
	logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, io_mode = 1'b0, card_rst_req = 1'b1, flag = 1'b0;
	logic wp_sw = 1'b0, vs1_n = 1'b1, vs2_n = 1'b1, busy, done, inpack_seen, card_reset, card_doe_n;
	logic rdy_ireq_in, wait_n, inpack_n, wp_in, io16, drv;
	logic [3:0] nwait = 4'h0;
	logic [15:0] rdata, card_dout, card_din;
	logic [25:0] card_addr;
	pcs_req_s req = '0;
	pcs_stat_s stat;
	pcs_strb_s strb, seen;
	int n_fail = 0, comparisons = 0, cyc;
	always #25 sys_clk = ~sys_clk;
	pcs_socket i_pcs_socket (.sys_clk, .nrst, .req_valid, .req, .io_mode, .card_rst_req, .stat, .busy, .done,
		.rdata, .inpack_seen, .strb, .card_reset, .card_addr, .card_dout, .card_doe_n, .card_din, .rdy_ireq_in,
		.wait_n, .inpack_n, .wp_in, .vs1_n, .vs2_n);
	pcs_card i_pcs_card (.sys_clk, .strb, .card_addr, .io_card(io_mode), .flag, .wp_sw, .nwait, .card_din,
		.rdy_ireq_in, .wait_n, .inpack_n, .wp_in);
	task chk(input logic ok);
		comparisons++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t mismatch", $time);
		end
	endtask : chk
	task results;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// one access, gathering strobes seen low
	task acc(input pcs_space_e sp, input logic wr, input logic [25:0] a, input logic wd);
		@(negedge sys_clk);
		req = {sp, wr, a, 16'hc35a, wd};
		req_valid = 1'b1;
		@(negedge sys_clk);
		req_valid = 1'b0;
		seen = '0;
		io16 = 1'b0;
		drv = 1'b0;
		for (cyc = 0; cyc < 40 && done !== 1'b1; cyc++) begin
			seen = seen | ~strb;
			io16 = io16 | stat.iois16;
			drv = drv | !card_doe_n;
			@(negedge sys_clk);
		end
		chk(done);
		if (done !== 1'b1)
			results();
	endtask : acc
	task t_mem;
		acc(PCS_MEM, 1'b0, 26'h0100, 1'b0);
		chk(seen === 7'h50 && cyc == PCS_SETUP_CYC + PCS_STRB_CYC + PCS_HOLD_CYC && drv === 1'b0);
		acc(PCS_ATTR, 1'b1, 26'h0003, 1'b0);
		chk(seen === 7'h29 && drv === 1'b1 && card_dout === 16'hc35a && card_addr === 26'h000_0003);
		nwait = 4'h3;
		acc(PCS_MEM, 1'b0, 26'h0000, 1'b1);
		nwait = 4'h0;
		chk(cyc == PCS_SETUP_CYC + PCS_STRB_CYC + PCS_HOLD_CYC + 3 && seen === 7'h70);
		$display("memory test done");
	endtask : t_mem
	task t_io;
		io_mode = 1'b1;
		acc(PCS_IO, 1'b0, 26'h0024, 1'b1);
		chk(seen === 7'h65 && inpack_seen === 1'b1 && rdata === 16'h0024 && io16 === 1'b1);
		acc(PCS_IO, 1'b1, 26'h0031, 1'b1);
		chk(seen === 7'h63 && drv === 1'b1 && card_dout === 16'hc35a);
		io_mode = 1'b0;
		$display("io test done");
	endtask : t_io
	task t_stat;
		for (int i = 0; i < 4; i++) begin
			{vs2_n, vs1_n} = 2'(i);
			flag = i[0];
			wp_sw = !i[0];
			io_mode = i[1];
			repeat (2) @(negedge sys_clk);
			chk(stat.volt === 2'(i));
			if (i < 2)
				chk(stat.ready === !flag && stat.wprot === wp_sw);
			else
				chk(stat.ireq === flag && stat.iois16 === 1'b0);
		end
		io_mode = 1'b0;
		$display("status test done");
	endtask : t_stat
	task t_rst;
		req_valid = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(card_reset === 1'b1 && busy === 1'b0);
		req_valid = 1'b0;
		card_rst_req = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(card_reset === 1'b0);
		// reserved space must start no access
		req = {PCS_RSVD, 1'b0, 26'h000_0000, 16'h0000, 1'b0};
		req_valid = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(busy === 1'b0 && strb === PCS_STRB_IDLE);
		req_valid = 1'b0;
		$display("reset test done");
	endtask : t_rst
	initial begin
		repeat (10) @(negedge sys_clk);
		nrst = 1'b1;
		t_rst();
		t_mem();
		t_io();
		t_stat();
		results();
	end
endmodule : tb
